// >>> design/wdt_consts.svh
// Summary of operation
// - timeout interval comes from a selectable tap of a system-clock divider chain.
// - 512 clocks before timeout set the interrupt flag; reset the processor only if enabled.
// - interrupt request only while flag, watchdog enable and global enable are set.
// - timeout reset and timeout interrupt act independently of each other.
// - global interrupt enable is bit 7 of interrupt_enable; 1 enables all.
// - control bits: flag 3, cause 2, reset enable 1, restart 0; reset zero.
// - software writing the flag to 1 acts like a hardware timeout.
// - clearing the interrupt flag works only through the timed-access unlock.
// - interrupt goes to vector 0x63, natural priority 11; no auto clear.
// - restart before timeout clears the count so timing starts from zero.
// - timeout with reset enabled and no restart asserts a processor reset.
// - the restart bit clears itself and always reads back as zero.
// - a watchdog reset sets the cause flag; it stays until software clears it.
// - interval field in bits 7:6 of clock_control_reg selects the timeout.
// - interrupt flag is set 512 clocks before the reset point.
// - a watchdog reset does not stop the watchdog; count restarts from zero.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// register byte offsets
`define WDT_OFS_IE 8'hA8
`define WDT_OFS_CLK 8'hB0
`define WDT_OFS_CTRL 8'hD8
`define WDT_OFS_EIE 8'hE8
`define WDT_OFS_EIP 8'hF8

// field positions
`define WDT_IE_GLOBAL 7
`define WDT_EIE_WDOG 4
`define WDT_EIP_WDOG 4
`define WDT_CTL_IRQF 3
`define WDT_CTL_CAUSE 2
`define WDT_CTL_RSTEN 1
`define WDT_CTL_RESTART 0
`define WDT_CKC_SEL_HI 7
`define WDT_CKC_SEL_LO 6

// reset values
`define WDT_RST_BYTE 8'h00

// timing
`define WDT_FLAG_LEAD 512
`define WDT_TAP_BASE 17
`define WDT_TAP_STEP 3

// interrupt dispatch
`define WDT_IRQ_VECTOR 8'h63
`define WDT_IRQ_NATPRIO 4'hB

`endif

// >>> design/wdt_pkg.sv
package wdt_pkg;

  // interrupt request bundle towards the interrupt controller
  typedef struct packed {
    logic req;
    logic highPrio;
    logic [7:0] vector;
    logic [3:0] natPrio;
  } wdt_irq_t;

  // watchdog control bits held by hardware
  typedef struct packed {
    logic irqFlag;
    logic causeFlag;
    logic resetEn;
  } wdt_ctrl_t;

endpackage : wdt_pkg

// >>> design/wdt_unit.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_unit #(
  parameter int TAP_BASE = `WDT_TAP_BASE,
  parameter int TAP_STEP = `WDT_TAP_STEP,
  parameter int CNT_W = TAP_BASE + 3 * TAP_STEP + 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timed-access unlock pulse
  input wire logic taUnlock,
  // watchdog results
  output logic cpuReset,
  output wdt_pkg::wdt_irq_t irqOut
);

  // tap value of the divider chain for an interval select code
  function automatic logic [CNT_W-1:0] tapLimit(input logic [1:0] sel);
    int shiftAmt;
    shiftAmt = TAP_BASE + TAP_STEP * int'(sel);
    tapLimit = CNT_W'(1) << shiftAmt;
  endfunction : tapLimit

  // address decode for one register offset
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit

  // true for any implemented register address
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == `WDT_OFS_IE) || (addr == `WDT_OFS_CLK) ||
               (addr == `WDT_OFS_CTRL) || (addr == `WDT_OFS_EIE) ||
               (addr == `WDT_OFS_EIP);
  endfunction : isMapped

  // reset synchroniser stages
  logic rstMeta_b;
  logic rstSync_b;

  // software-visible register storage
  logic [7:0] ieReg_r;
  logic [7:0] eieReg_r;
  logic [7:0] eipReg_r;
  logic [7:0] clkCtlReg_r;
  wdt_pkg::wdt_ctrl_t ctrl_r;
  logic unlockArmed_r;

  // watchdog count
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // registered outputs
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic cpuReset_r;
  wdt_pkg::wdt_irq_t irq_r;

  // decoded and derived values
  logic [7:0] rdMux;
  logic [1:0] intervalSel;
  logic [CNT_W-1:0] limitVal;
  logic [CNT_W-1:0] flagPoint;

  // protected write and timeout event strobes
  logic ctrlWrOk;
  logic restartReq;
  logic reachLimit;
  logic flagHit;
  logic resetHit;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // apb phase and write strobes
  logic setupPh;
  logic accessWr;
  logic wrIe;
  logic wrClk;
  logic wrCtrl;
  logic wrEie;
  logic wrEip;

  assign setupPh = psel & ~penable;
  assign accessWr = psel & penable & pwrite;
  assign wrIe = accessWr & regHit(paddr, `WDT_OFS_IE);
  assign wrClk = accessWr & regHit(paddr, `WDT_OFS_CLK);
  assign wrCtrl = accessWr & regHit(paddr, `WDT_OFS_CTRL);
  assign wrEie = accessWr & regHit(paddr, `WDT_OFS_EIE);
  assign wrEip = accessWr & regHit(paddr, `WDT_OFS_EIP);

  // a control write only lands while the unlock is armed
  assign ctrlWrOk = wrCtrl & unlockArmed_r;
  assign restartReq = ctrlWrOk & pwdata[`WDT_CTL_RESTART];

  // divider tap and the two event points derived from it
  assign intervalSel = clkCtlReg_r[`WDT_CKC_SEL_HI:`WDT_CKC_SEL_LO];
  assign limitVal = tapLimit(intervalSel);
  assign flagPoint = limitVal - CNT_W'(`WDT_FLAG_LEAD);

  // timeout events; an interval change below the count still hits via >=
  assign reachLimit = (count_r >= limitVal);
  assign flagHit = (count_r == flagPoint) & ~restartReq;
  assign resetHit = reachLimit & ctrl_r.resetEn & ~restartReq;

  // no wait states, so the slave is always ready
  assign pready = 1'b1;

  // output ports follow their registers
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign cpuReset = cpuReset_r;
  assign irqOut = irq_r;

  // read multiplexer; unused control bits and restart read zero
  always_comb begin
    rdMux = 8'h00;
    case (paddr)
      `WDT_OFS_IE: rdMux = ieReg_r;
      `WDT_OFS_CLK: rdMux = clkCtlReg_r;
      `WDT_OFS_CTRL: begin
        rdMux[`WDT_CTL_IRQF] = ctrl_r.irqFlag;
        rdMux[`WDT_CTL_CAUSE] = ctrl_r.causeFlag;
        rdMux[`WDT_CTL_RSTEN] = ctrl_r.resetEn;
        rdMux[`WDT_CTL_RESTART] = 1'b0;
      end
      `WDT_OFS_EIE: rdMux = eieReg_r;
      `WDT_OFS_EIP: rdMux = eipReg_r;
      default: rdMux = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle and held until the next one
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata_r <= {24'h00_0000, rdMux};
    end
  end

  // bus error for an unmapped offset, captured alongside the read data
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pslverr_r <= 1'b0;
    end else if (setupPh) begin
      pslverr_r <= ~isMapped(paddr);
    end
  end

  // interrupt enable register, global enable in bit 7
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ieReg_r <= `WDT_RST_BYTE;
    end else if (wrIe) begin
      ieReg_r <= pwdata[7:0];
    end
  end

  // extended enable register, watchdog enable in bit 4
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      eieReg_r <= `WDT_RST_BYTE;
    end else if (wrEie) begin
      eieReg_r <= pwdata[7:0];
    end
  end

  // extended priority register, watchdog priority in bit 4
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      eipReg_r <= `WDT_RST_BYTE;
    end else if (wrEip) begin
      eipReg_r <= pwdata[7:0];
    end
  end

  // clock control register holding the interval select
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      clkCtlReg_r <= `WDT_RST_BYTE;
    end else if (wrClk) begin
      clkCtlReg_r <= pwdata[7:0];
    end
  end

  // unlock: armed by the pulse, spent by one control write
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      unlockArmed_r <= 1'b0;
    end else if (taUnlock) begin
      unlockArmed_r <= 1'b1;
    end else if (wrCtrl) begin
      unlockArmed_r <= 1'b0;
    end
  end

  // free-running count, cleared by restart or at the reset point
  always_comb begin
    if (restartReq || reachLimit) begin
      count_nxt = '0;
    end else begin
      count_nxt = count_r + CNT_W'(1);
    end
  end

  // count register, cleared by the synchronised reset, otherwise loads count_nxt
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // interrupt flag: hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_r.irqFlag <= 1'b0;
    end else if (flagHit) begin
      ctrl_r.irqFlag <= 1'b1;
    end else if (ctrlWrOk) begin
      ctrl_r.irqFlag <= pwdata[`WDT_CTL_IRQF];
    end
  end

  // reset-cause flag: set by a watchdog reset, kept until cleared
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_r.causeFlag <= 1'b0;
    end else if (resetHit) begin
      ctrl_r.causeFlag <= 1'b1;
    end else if (ctrlWrOk) begin
      ctrl_r.causeFlag <= pwdata[`WDT_CTL_CAUSE];
    end
  end

  // reset enable, only through an unlocked write
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_r.resetEn <= 1'b0;
    end else if (ctrlWrOk) begin
      ctrl_r.resetEn <= pwdata[`WDT_CTL_RSTEN];
    end
  end

  // one-cycle processor reset pulse
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cpuReset_r <= 1'b0;
    end else begin
      cpuReset_r <= resetHit;
    end
  end

  // interrupt request level from the flag and both enables
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irq_r.req <= 1'b0;
    end else begin
      irq_r.req <= ctrl_r.irqFlag & eieReg_r[`WDT_EIE_WDOG] &
                   ieReg_r[`WDT_IE_GLOBAL];
    end
  end

  // priority level follows the watchdog priority bit
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irq_r.highPrio <= 1'b0;
    end else begin
      irq_r.highPrio <= eipReg_r[`WDT_EIP_WDOG];
    end
  end

  // fixed dispatch data, loaded once reset has been released
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irq_r.vector <= 8'h00;
      irq_r.natPrio <= 4'h0;
    end else begin
      irq_r.vector <= `WDT_IRQ_VECTOR;
      irq_r.natPrio <= `WDT_IRQ_NATPRIO;
    end
  end

endmodule : wdt_unit

// >>> dv/wdt_unit_monitor.sv
`timescale 1ns/1ps
module wdt_unit_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // unlock and results
  input wire logic taUnlock,
  input wire logic cpuReset,
  input wire wdt_pkg::wdt_irq_t irqOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // dispatch fields, reset request shape and read data shape
  a_vector_fixed: assert property ($past(rst_b, 4) |-> irqOut.natPrio == 4'hB &&
    irqOut.vector == 8'h63) else $error("vector or priority wrong");
  a_reset_pulse: assert property (cpuReset |=> !cpuReset) else $error("reset too long");
  a_reset_gap: assert property ($fell(cpuReset) |-> !cpuReset [*8])
    else $error("reset repeats at once");
  a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper read bits");
  a_slave_err: assert property (psel && !penable |=> pslverr ==
    !($past(paddr) inside {8'hA8, 8'hB0, 8'hD8, 8'hE8, 8'hF8})) else $error("pslverr wrong");
  a_ctrl_read: assert property (psel && !penable && !pwrite && paddr == 8'hD8 |=>
    !prdata[0] && prdata[7:4] == 4'h0) else $error("control read bits");
  // priority changes and request drops only after a register write
  a_prio_cause: assert property ($changed(irqOut.highPrio) |->
    $past(psel && penable && pwrite && paddr == 8'hF8, 2)) else $error("priority moved");
  a_req_drop: assert property ($fell(irqOut.req) |-> $past(psel && penable && pwrite, 2))
    else $error("request dropped alone");
endmodule : wdt_unit_monitor

bind wdt_unit wdt_unit_monitor mon_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .taUnlock(taUnlock), .cpuReset(cpuReset),
  .irqOut(irqOut));

// >>> dv/wdt_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module wdt_unit_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic taUnlock = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpuReset;
  wdt_pkg::wdt_irq_t irqOut;
  logic [31:0] expQ[$];
  logic [31:0] e;
  logic [31:0] rnd = 32'h12;
  logic [7:0] regs[4] = '{8'hA8, 8'hB0, 8'hE8, 8'hF8};
  int errors = 0;
  int checks = 0;
  int t;

  always #2 clk_sys = ~clk_sys;

  // short taps give timeouts of 1024 to 8192 cycles; interval 1 used here gives 2048
  wdt_unit #(.TAP_BASE(10), .TAP_STEP(1)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .taUnlock(taUnlock), .cpuReset(cpuReset),
    .irqOut(irqOut));

  task automatic complete_run;
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs

  // one apb transfer, held until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expQ.push_back(x);
    apb(1'b0, a, 8'h00);
  endtask : rd

  // protected control write behind an unlock pulse
  task automatic ul(input logic [7:0] d);
    taUnlock <= 1'b1;
    @(posedge clk_sys);
    taUnlock <= 1'b0;
    apb(1'b1, 8'hD8, d);
  endtask : ul

  // count cycles until reset request or interrupt request shows
  task automatic waitEv(input bit onRst, input int lim, input bit must);
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while ((onRst ? cpuReset : irqOut.req) !== 1'b1 && t < lim);
    if (must && t >= lim) begin
      errors++;
      complete_run();
    end
  endtask : waitEv

  // compare each completed read with the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready) begin
      e = expQ.pop_front();
      `CHK(prdata, e)
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ul(8'h01);
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(8'hD8, 32'h0);
    rd(8'h00, 32'h0);
    foreach (regs[i]) begin
      rnd = xs(rnd);
      apb(1'b1, regs[i], rnd[7:0]);
      rd(regs[i], {24'h0, rnd[7:0]});
    end
    apb(1'b1, 8'hA8, 8'h80);
    apb(1'b1, 8'hE8, 8'h10);
    apb(1'b1, 8'hF8, 8'h10);
    apb(1'b1, 8'hB0, 8'h40);
    apb(1'b1, 8'hD8, 8'h08);
    rd(8'hD8, 32'h0);
    ul(8'h08);
    rd(8'hD8, 32'h8);
    `CHK({irqOut.req, irqOut.highPrio}, 2'b11)
    apb(1'b1, 8'hD8, 8'h00);
    rd(8'hD8, 32'h8);
    ul(8'h00);
    rd(8'hD8, 32'h0);
    ul(8'h01);
    ul(8'h02);
    waitEv(1'b0, 3000, 1'b1);
    waitEv(1'b1, 600, 1'b1);
    `CHK(t inside {[510:513]}, 1'b1)
    waitEv(1'b1, 2100, 1'b1);
    `CHK(t inside {[2047:2049]}, 1'b1)
    rd(8'hD8, 32'hE);
    repeat (3) begin
      ul(8'h03);
      waitEv(1'b1, 1500, 1'b0);
      `CHK(t, 1500)
    end
    ul(8'h00);
    waitEv(1'b1, 2500, 1'b0);
    `CHK(t, 2500)
    rd(8'hD8, 32'h8);
    complete_run();
  end
endmodule : wdt_unit_tb_top
